// >>> ladder_latch_interlock_jump_test.sv
/*
 * Self-checking bench of the scan engine: latch, interlock, jump and edge handling, and retention.
 * Assumes llij_prog_model as the program store and bit memory; one scan runs per scan() call.
 */
`timescale 1ns/1ps

module ladder_latch_interlock_jump_test;
	logic                      ref_clk_i;
	logic                      rst_i;
	logic                      run;
	logic                      tbl_wr;
	logic [6:0]                tbl_num;
	logic [10:0]               tbl_addr;
	logic [10:0]               fetch;
	logic                      scan_done;
	logic                      il_warn;
	logic                      clr_vol;
	logic                      warn_seen;
	logic                      instr_valid;
	llij_pkg::llij_instr_type  instr;
	llij_pkg::llij_act_type    act;
	logic [3:0]                rec [0:255];
	logic [3:0]                seq [0:6];
	int                        err_total = 0;
	int                        tests_run = 0;
	int                        cycles    = 0;

	llij_scan_engine DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid), .instr_i(instr),
		.fetch_addr_o(fetch), .tbl_wr_i(tbl_wr), .tbl_num_i(tbl_num), .tbl_addr_i(tbl_addr), .act_o(act),
		.scan_done_o(scan_done), .il_warn_o(il_warn), .clear_volatile_o(clr_vol));
	llij_prog_model pm (.ref_clk_i(ref_clk_i), .run_i(run), .fetch_addr_i(fetch), .act_i(act),
		.clear_volatile_i(clr_vol), .instr_valid_o(instr_valid), .instr_o(instr));

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// ==========================================================================
	// Monitor and timeout
	// ==========================================================================
	// Each action is logged under the low byte of its bit address, which is unique per program.
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (act.valid === 1'b1) begin
			rec[act.bit_addr[7:0]] <= {1'b1, act.mode, act.value};
		end
		if (il_warn === 1'b1) begin
			warn_seen <= 1'b1;
		end
		if (cycles == 5000) begin
			err_total = err_total + 1;
			finish_test();
		end
	end

	// ==========================================================================
	// Helpers
	// ==========================================================================
	function automatic llij_pkg::llij_instr_type mk(llij_pkg::llij_op_type op, logic [15:0] a, logic ca,
		logic [6:0] jn = 7'h00);
		return '{op, jn, a, 6'h00, ca, 1'b0, 1'b0};
	endfunction : mk

	function automatic logic [3:0] ex(llij_pkg::llij_mode_type m, logic v);
		return {1'b1, m, v};
	endfunction : ex

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic scan();
		int n;
		for (n = 0; n < 256; n++) begin
			rec[n] = 4'h0;
		end
		warn_seen = 1'b0;
		run = 1'b1;
		n = 0;
		while (scan_done !== 1'b1 && n < 100) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		run = 1'b0;
		check(4'(scan_done), 4'h1);
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask : scan

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic test_latch();
		pm.prog[1] = mk(llij_pkg::OP_LATCH, 16'h8001, 1'b0);
		pm.prog[2] = mk(llij_pkg::OP_END, 16'h00FF, 1'b0);
		seq = '{4'h5, 4'h1, 4'h2, 4'h0, 4'h5, 4'h6, 4'h0};
		for (int i = 0; i < 7; i++) begin
			pm.prog[1].cond_a = seq[i][2];
			pm.prog[1].cond_b = seq[i][1];
			scan();
			check(4'(pm.mem[16'h8001]), {3'h0, seq[i][0]});
		end
	endtask : test_latch

	task automatic test_interlock();
		pm.prog[1] = mk(llij_pkg::OP_IL_OPEN, 16'h00F1, 1'b0);
		pm.prog[2] = mk(llij_pkg::OP_OUT, 16'h0010, 1'b1);
		pm.prog[3] = mk(llij_pkg::OP_TIMER_STD, 16'h0011, 1'b1);
		pm.prog[4] = mk(llij_pkg::OP_IL_OPEN, 16'h00F2, 1'b0);
		pm.prog[5] = mk(llij_pkg::OP_OUT_NOT, 16'h0012, 1'b0);
		pm.prog[6] = mk(llij_pkg::OP_TIMER_TOT, 16'h0013, 1'b1);
		pm.prog[7] = mk(llij_pkg::OP_SET, 16'h0014, 1'b1);
		pm.prog[8] = mk(llij_pkg::OP_LATCH, 16'h8002, 1'b1);
		pm.prog[9] = mk(llij_pkg::OP_IL_CLEAR, 16'h00F3, 1'b0);
		pm.prog[10] = mk(llij_pkg::OP_OUT, 16'h0015, 1'b1);
		pm.prog[11] = mk(llij_pkg::OP_END, 16'h00FF, 1'b0);
		scan();
		check(rec[8'h10], ex(llij_pkg::ACT_WRITE, 1'b0));
		check(rec[8'h11] >> 1, ex(llij_pkg::ACT_RESET_SV, 1'b0) >> 1);
		check(rec[8'h12], ex(llij_pkg::ACT_WRITE, 1'b0));
		check(rec[8'h13] >> 1, ex(llij_pkg::ACT_HOLD, 1'b0) >> 1);
		check(rec[8'h14], 4'h0);
		check(4'(pm.mem[16'h8002]), 4'h0);
		check(rec[8'h15], ex(llij_pkg::ACT_WRITE, 1'b1));
		check(4'(warn_seen), 4'h1);
		pm.prog[1].cond_a = 1'b1;
		scan();
		check(rec[8'h10], ex(llij_pkg::ACT_WRITE, 1'b1));
		check(rec[8'h11] >> 1, ex(llij_pkg::ACT_RUN, 1'b0) >> 1);
		check(rec[8'h12], ex(llij_pkg::ACT_WRITE, 1'b0));
		check(rec[8'h13] >> 1, ex(llij_pkg::ACT_HOLD, 1'b0) >> 1);
		pm.prog[4].cond_a = 1'b1;
		scan();
		check(rec[8'h12], ex(llij_pkg::ACT_WRITE, 1'b1));
		check(rec[8'h14], ex(llij_pkg::ACT_WRITE, 1'b1));
		check(4'(pm.mem[16'h8002]), 4'h1);
	endtask : test_interlock

	task automatic test_jump();
		tbl_num = 7'h07;
		tbl_addr = 11'h005;
		tbl_wr = 1'b1;
		@(posedge ref_clk_i);
		#1;
		tbl_wr = 1'b0;
		pm.prog[1] = mk(llij_pkg::OP_JUMP, 16'h00F4, 1'b1, 7'h07);
		pm.prog[2] = mk(llij_pkg::OP_OUT, 16'h0020, 1'b1);
		pm.prog[3] = mk(llij_pkg::OP_TIMER_STD, 16'h0021, 1'b1);
		pm.prog[4] = mk(llij_pkg::OP_NOP, 16'h0000, 1'b0);
		pm.prog[5] = mk(llij_pkg::OP_JUMP_END, 16'h00F5, 1'b0, 7'h07);
		pm.prog[6] = mk(llij_pkg::OP_OUT, 16'h0022, 1'b1);
		pm.prog[7] = mk(llij_pkg::OP_END, 16'h00FF, 1'b0);
		scan();
		check(rec[8'h20], ex(llij_pkg::ACT_WRITE, 1'b1));
		pm.prog[1].cond_a = 1'b0;
		scan();
		check(rec[8'h20], 4'h0);
		check(rec[8'h21], 4'h0);
		check(rec[8'h22], ex(llij_pkg::ACT_WRITE, 1'b1));
		check(4'(pm.mem[16'h0020]), 4'h1);
		pm.prog[1] = mk(llij_pkg::OP_JUMP, 16'h00F6, 1'b0);
		pm.prog[2] = mk(llij_pkg::OP_OUT, 16'h0030, 1'b1);
		pm.prog[3] = mk(llij_pkg::OP_JUMP, 16'h00F7, 1'b0);
		pm.prog[4] = mk(llij_pkg::OP_OUT, 16'h0031, 1'b1);
		pm.prog[5] = mk(llij_pkg::OP_JUMP_END, 16'h00F8, 1'b0);
		pm.prog[6] = mk(llij_pkg::OP_OUT, 16'h0032, 1'b1);
		pm.prog[7] = mk(llij_pkg::OP_JUMP_END, 16'h00F9, 1'b0);
		pm.prog[8] = mk(llij_pkg::OP_OUT, 16'h0033, 1'b1);
		pm.prog[9] = mk(llij_pkg::OP_END, 16'h00FF, 1'b0);
		scan();
		check(rec[8'h30], 4'h0);
		check(rec[8'h31], 4'h0);
		check(rec[8'h32], ex(llij_pkg::ACT_WRITE, 1'b1));
		check(rec[8'h33], ex(llij_pkg::ACT_WRITE, 1'b1));
		// The first jump now runs through, so the second jump 00 shares the same jump-end.
		pm.prog[1].cond_a = 1'b1;
		scan();
		check(rec[8'h30], ex(llij_pkg::ACT_WRITE, 1'b1));
		check(rec[8'h31], 4'h0);
		check(rec[8'h32], ex(llij_pkg::ACT_WRITE, 1'b1));
	endtask : test_jump

	task automatic test_edge();
		pm.prog[1] = mk(llij_pkg::OP_IL_OPEN, 16'h00FA, 1'b1);
		pm.prog[2] = mk(llij_pkg::OP_RISE, 16'h0040, 1'b1);
		pm.prog[3] = mk(llij_pkg::OP_IL_CLEAR, 16'h00FB, 1'b0);
		pm.prog[4] = mk(llij_pkg::OP_END, 16'h00FF, 1'b0);
		seq = '{4'hF, 4'hE, 4'h0, 4'h4, 4'hE, 4'hA, 4'hF};
		for (int i = 0; i < 7; i++) begin
			pm.prog[1].cond_a = seq[i][3];
			pm.prog[2].cond_a = seq[i][2];
			scan();
			check({2'h0, rec[8'h40][3], rec[8'h40][0]}, {2'h0, seq[i][1:0]});
		end
	endtask : test_edge

	task automatic test_misc();
		pm.prog[1] = mk(llij_pkg::OP_IL_OPEN, 16'h00E0, 1'b0);
		pm.prog[2] = mk(llij_pkg::OP_TIMER_FAST, 16'h0060, 1'b1);
		pm.prog[3] = mk(llij_pkg::OP_COUNT_DOWN, 16'h0061, 1'b1);
		pm.prog[4] = mk(llij_pkg::OP_COUNT_REV, 16'h0062, 1'b1);
		pm.prog[5] = mk(llij_pkg::OP_OTHER, 16'h0063, 1'b1);
		pm.prog[6] = mk(llij_pkg::OP_RESET, 16'h0064, 1'b1);
		pm.prog[7] = mk(llij_pkg::OP_FALL, 16'h0065, 1'b1);
		pm.prog[8] = mk(llij_pkg::OP_IL_CLEAR, 16'h00E1, 1'b0);
		pm.prog[9] = mk(llij_pkg::OP_END, 16'h00FF, 1'b0);
		pm.prog[7].edge_idx = 6'h01;
		scan();
		check(rec[8'h60] >> 1, ex(llij_pkg::ACT_RESET_SV, 1'b0) >> 1);
		check(rec[8'h61] >> 1, ex(llij_pkg::ACT_HOLD, 1'b0) >> 1);
		check(rec[8'h62] >> 1, ex(llij_pkg::ACT_HOLD, 1'b0) >> 1);
		check(rec[8'h63], 4'h0);
		check(rec[8'h64], 4'h0);
		check(rec[8'h65], 4'h0);
		check(4'(warn_seen), 4'h0);
		// The falling-edge memory must still hold the value from before the interlock.
		pm.prog[1].cond_a = 1'b1;
		pm.prog[7].cond_a = 1'b0;
		scan();
		check(rec[8'h60] >> 1, ex(llij_pkg::ACT_RUN, 1'b0) >> 1);
		check(rec[8'h61] >> 1, ex(llij_pkg::ACT_RUN, 1'b0) >> 1);
		check(rec[8'h63] >> 1, ex(llij_pkg::ACT_RUN, 1'b0) >> 1);
		check(rec[8'h64], ex(llij_pkg::ACT_WRITE, 1'b0));
		check(rec[8'h65], ex(llij_pkg::ACT_WRITE, 1'b0));
		pm.prog[7].cond_a = 1'b1;
		scan();
		pm.prog[7].cond_a = 1'b0;
		scan();
		check(rec[8'h65], ex(llij_pkg::ACT_WRITE, 1'b1));
	endtask : test_misc

	task automatic test_retain();
		pm.mem[16'h0050] = 1'b1;
		pm.mem[16'h8050] = 1'b1;
		rst_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		@(posedge ref_clk_i);
		#1;
		check(4'(pm.mem[16'h0050]), 4'h0);
		check(4'(pm.mem[16'h8050]), 4'h1);
	endtask : test_retain

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		rst_i = 1'b1;
		run = 1'b0;
		tbl_wr = 1'b0;
		tbl_num = 7'h00;
		tbl_addr = 11'h000;
		warn_seen = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		pm.prog[0] = mk(llij_pkg::OP_NOP, 16'h0000, 1'b0);
		test_latch();
		test_interlock();
		test_jump();
		test_edge();
		test_misc();
		test_retain();
		finish_test();
	end
endmodule : ladder_latch_interlock_jump_test

// >>> llij_pkg.sv
/*
 * Shared constants and types of the ladder scan engine: instruction codes,
 * action modes, field widths and the packed instruction and action records.
 * Assumes the program store and bit memory agree on these encodings.
 */
package llij_pkg;

	// ==========================================================================
	// Widths and constants
	// ==========================================================================
	localparam int PROG_AW      = 11;
	localparam int BIT_AW       = 16;
	localparam int EDGE_AW      = 6;
	localparam int JNUM_W       = 7;
	localparam int JTBL_DEPTH   = 100;
	localparam int EDGE_DEPTH   = 64;
	localparam int IL_CNT_W     = 2;

	localparam logic [PROG_AW-1:0]  PC_RESET  = 11'h000;
	localparam logic [PROG_AW-1:0]  PC_STEP   = 11'h001;
	localparam logic [JNUM_W-1:0]   JNUM_ANY  = 7'h00;
	localparam logic [JNUM_W-1:0]   JNUM_MAX  = 7'h63;
	localparam logic [IL_CNT_W-1:0] IL_CNT_ZERO = 2'h0;
	localparam logic [IL_CNT_W-1:0] IL_CNT_ONE  = 2'h1;
	localparam logic [IL_CNT_W-1:0] IL_CNT_SAT  = 2'h3;

	// ==========================================================================
	// Instruction codes
	// ==========================================================================
	typedef enum logic [4:0] {
		OP_NOP         = 5'h00,
		OP_END         = 5'h01,
		OP_OUT         = 5'h02,
		OP_OUT_NOT     = 5'h03,
		OP_SET         = 5'h04,
		OP_RESET       = 5'h05,
		OP_LATCH       = 5'h06,
		OP_TIMER_STD   = 5'h07,
		OP_TIMER_FAST  = 5'h08,
		OP_TIMER_TOT   = 5'h09,
		OP_COUNT_DOWN  = 5'h0A,
		OP_COUNT_REV   = 5'h0B,
		OP_RISE        = 5'h0C,
		OP_FALL        = 5'h0D,
		OP_IL_OPEN     = 5'h0E,
		OP_IL_CLEAR    = 5'h0F,
		OP_JUMP        = 5'h10,
		OP_JUMP_END    = 5'h11,
		OP_OTHER       = 5'h12
	} llij_op_type;

	// What the executing unit must do with the instruction it is handed.
	typedef enum logic [1:0] {
		ACT_RUN      = 2'h0,
		ACT_WRITE    = 2'h1,
		ACT_RESET_SV = 2'h2,
		ACT_HOLD     = 2'h3
	} llij_mode_type;

	typedef struct packed {
		llij_op_type         op;
		logic [JNUM_W-1:0]   jump_num;
		logic [BIT_AW-1:0]   bit_addr;
		logic [EDGE_AW-1:0]  edge_idx;
		logic                cond_a;
		logic                cond_b;
		logic                bit_now;
	} llij_instr_type;

	typedef struct packed {
		logic                valid;
		llij_op_type         op;
		llij_mode_type       mode;
		logic [BIT_AW-1:0]   bit_addr;
		logic                value;
	} llij_act_type;

endpackage : llij_pkg

// >>> llij_prog_model.sv
/*
 * Partner model of the scan engine's far side: the stored program and the bit data memory.
 * Assumes the bench loads prog and presets mem while run_i is low, and reads them directly.
 */
`timescale 1ns/1ps

module llij_prog_model (
	// Clock
	input  wire logic                          ref_clk_i,
	// Bench control
	input  wire logic                          run_i,
	// Engine side
	input  wire logic [llij_pkg::PROG_AW-1:0]  fetch_addr_i,
	input  wire llij_pkg::llij_act_type        act_i,
	input  wire logic                          clear_volatile_i,
	output logic                               instr_valid_o,
	output llij_pkg::llij_instr_type           instr_o
);
	llij_pkg::llij_instr_type  prog [0:63];
	logic                      mem  [0:65535];

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 1'b0;
		end
		for (int i = 0; i < 64; i++) begin
			prog[i] = '0;
		end
	end

	// ==========================================================================
	// Program store
	// ==========================================================================
	// Outside a scan the lines show an inverted word so stale values are never mistaken for data.
	always @* begin
		instr_o         = prog[fetch_addr_i[5:0]];
		instr_o.bit_now = mem[instr_o.bit_addr];
		if (!run_i) begin
			instr_o = ~instr_o;
		end
		instr_valid_o = run_i;
	end

	// ==========================================================================
	// Bit memory
	// ==========================================================================
	// Only the lower half is volatile; the upper half stands for the holding and auxiliary areas.
	always @(posedge ref_clk_i) begin
		if (clear_volatile_i) begin
			for (int i = 0; i < 32768; i++) begin
				mem[i] <= 1'b0;
			end
		end else if (act_i.valid && act_i.mode == llij_pkg::ACT_WRITE) begin
			mem[act_i.bit_addr] <= act_i.value;
		end
	end
endmodule : llij_prog_model

// >>> llij_scan_engine.sv
/*
 * Ladder scan engine: steps through the program one instruction per clock,
 * applies interlock and jump treatment, and issues at most one action per executed
 * instruction. Assumes the program store returns the instruction at
 * fetch_addr_o in the same cycle and the caller computes execution conditions.
 */
`timescale 1ns/1ps

module llij_scan_engine (
	// Clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_i,
	// Program store
	input  wire logic                          instr_valid_i,
	input  wire llij_pkg::llij_instr_type      instr_i,
	output logic [llij_pkg::PROG_AW-1:0]       fetch_addr_o,
	// Jump-end address table load
	input  wire logic                          tbl_wr_i,
	input  wire logic [llij_pkg::JNUM_W-1:0]   tbl_num_i,
	input  wire logic [llij_pkg::PROG_AW-1:0]  tbl_addr_i,
	// Actions and status
	output llij_pkg::llij_act_type             act_o,
	output logic                               scan_done_o,
	output logic                               il_warn_o,
	output logic                               clear_volatile_o
);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef enum logic {
		ST_RUN    = 1'b0,
		ST_SEARCH = 1'b1
	} llij_state_type;

	llij_state_type                  state_reg;
	logic [llij_pkg::PROG_AW-1:0]    pc_reg;
	logic                            il_off_reg;
	logic [llij_pkg::IL_CNT_W-1:0]   il_cnt_reg;
	logic                            warn_reg;
	logic                            done_reg;
	logic                            clr_reg;
	llij_pkg::llij_act_type          act_reg;
	logic [llij_pkg::PROG_AW-1:0]    jtbl_reg [llij_pkg::JTBL_DEPTH];
	logic                            edge_prev_reg [llij_pkg::EDGE_DEPTH];

	logic                            run_now;
	logic                            take_jump;
	logic                            jump_numbered;
	logic                            prev_now;
	logic [llij_pkg::PROG_AW-1:0]    jump_target;

	always_comb begin
		run_now       = instr_valid_i && (state_reg == ST_RUN);
		// A jump inside an interlock that is off is not executed.
		take_jump     = run_now && (instr_i.op == llij_pkg::OP_JUMP) && !instr_i.cond_a && !il_off_reg;
		jump_numbered = (instr_i.jump_num != llij_pkg::JNUM_ANY) && (instr_i.jump_num <= llij_pkg::JNUM_MAX);
		jump_target   = llij_pkg::PC_RESET;
		if (jump_numbered) begin
			jump_target = jtbl_reg[instr_i.jump_num] + llij_pkg::PC_STEP;
		end
		prev_now      = edge_prev_reg[instr_i.edge_idx];
	end

	// ==========================================================================
	// Jump-end table
	// ==========================================================================
	always_ff @(posedge ref_clk_i) begin
		if (tbl_wr_i && (tbl_num_i != llij_pkg::JNUM_ANY) && (tbl_num_i <= llij_pkg::JNUM_MAX)) begin
			jtbl_reg[tbl_num_i] <= tbl_addr_i;
		end
	end

	// ==========================================================================
	// Program counter and search state
	// ==========================================================================
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pc_reg <= llij_pkg::PC_RESET;
		end else if (instr_valid_i) begin
			if (instr_i.op == llij_pkg::OP_END) begin
				pc_reg <= llij_pkg::PC_RESET;
			end else if (take_jump && jump_numbered) begin
				pc_reg <= jump_target;
			end else begin
				pc_reg <= pc_reg + llij_pkg::PC_STEP;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= ST_RUN;
		end else if (instr_valid_i) begin
			if (instr_i.op == llij_pkg::OP_END) begin
				state_reg <= ST_RUN;
			end else if (take_jump && !jump_numbered) begin
				state_reg <= ST_SEARCH;
			end else if ((state_reg == ST_SEARCH) && (instr_i.op == llij_pkg::OP_JUMP_END)
				&& (instr_i.jump_num == llij_pkg::JNUM_ANY)) begin
				state_reg <= ST_RUN;
			end
		end
	end

	// ==========================================================================
	// Interlock tracking
	// ==========================================================================
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			il_off_reg <= 1'b0;
			il_cnt_reg <= llij_pkg::IL_CNT_ZERO;
			warn_reg   <= 1'b0;
		end else begin
			warn_reg <= 1'b0;
			if (instr_valid_i && (instr_i.op == llij_pkg::OP_END)) begin
				il_off_reg <= 1'b0;
				il_cnt_reg <= llij_pkg::IL_CNT_ZERO;
			end else if (run_now && (instr_i.op == llij_pkg::OP_IL_OPEN)) begin
				// Each open narrows the section from its own position onward.
				il_off_reg <= il_off_reg || !instr_i.cond_a;
				if (il_cnt_reg != llij_pkg::IL_CNT_SAT) begin
					il_cnt_reg <= il_cnt_reg + llij_pkg::IL_CNT_ONE;
				end
			end else if (run_now && (instr_i.op == llij_pkg::OP_IL_CLEAR)) begin
				il_off_reg <= 1'b0;
				il_cnt_reg <= llij_pkg::IL_CNT_ZERO;
				warn_reg   <= il_cnt_reg > llij_pkg::IL_CNT_ONE;
			end
		end
	end

	// ==========================================================================
	// Edge detector memory
	// ==========================================================================
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < llij_pkg::EDGE_DEPTH; i++) begin
				edge_prev_reg[i] <= 1'b0;
			end
		end else if (run_now && !il_off_reg
			&& ((instr_i.op == llij_pkg::OP_RISE) || (instr_i.op == llij_pkg::OP_FALL))) begin
			edge_prev_reg[instr_i.edge_idx] <= instr_i.cond_a;
		end
	end

	// ==========================================================================
	// Action issue
	// ==========================================================================
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			act_reg <= '0;
		end else begin
			act_reg          <= '0;
			act_reg.op       <= instr_i.op;
			act_reg.bit_addr <= instr_i.bit_addr;
			act_reg.mode     <= llij_pkg::ACT_RUN;
			act_reg.value    <= instr_i.cond_a;
			// Nothing is issued while searching, so skipped state stays put.
			if (run_now) begin
				unique case (instr_i.op)
					llij_pkg::OP_OUT, llij_pkg::OP_OUT_NOT: begin
						act_reg.valid <= 1'b1;
						act_reg.mode  <= llij_pkg::ACT_WRITE;
						act_reg.value <= !il_off_reg && (instr_i.cond_a ^ (instr_i.op == llij_pkg::OP_OUT_NOT));
					end
					llij_pkg::OP_SET, llij_pkg::OP_RESET: begin
						act_reg.valid <= !il_off_reg && instr_i.cond_a;
						act_reg.mode  <= llij_pkg::ACT_WRITE;
						act_reg.value <= instr_i.op == llij_pkg::OP_SET;
					end
					llij_pkg::OP_LATCH: begin
						act_reg.valid <= !il_off_reg;
						act_reg.mode  <= llij_pkg::ACT_WRITE;
						if (instr_i.cond_b) begin
							act_reg.value <= 1'b0;
						end else if (instr_i.cond_a) begin
							act_reg.value <= 1'b1;
						end else begin
							act_reg.value <= instr_i.bit_now;
						end
					end
					llij_pkg::OP_TIMER_STD, llij_pkg::OP_TIMER_FAST: begin
						act_reg.valid <= 1'b1;
						if (il_off_reg) begin
							act_reg.mode <= llij_pkg::ACT_RESET_SV;
						end
					end
					llij_pkg::OP_TIMER_TOT, llij_pkg::OP_COUNT_DOWN, llij_pkg::OP_COUNT_REV: begin
						act_reg.valid <= 1'b1;
						if (il_off_reg) begin
							act_reg.mode <= llij_pkg::ACT_HOLD;
						end
					end
					llij_pkg::OP_RISE, llij_pkg::OP_FALL: begin
						act_reg.valid <= !il_off_reg;
						act_reg.mode  <= llij_pkg::ACT_WRITE;
						if (instr_i.op == llij_pkg::OP_RISE) begin
							act_reg.value <= instr_i.cond_a && !prev_now;
						end else begin
							act_reg.value <= !instr_i.cond_a && prev_now;
						end
					end
					llij_pkg::OP_OTHER: begin
						act_reg.valid <= !il_off_reg;
					end
					default: begin
						act_reg.valid <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================================
	// Scan status
	// ==========================================================================
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
			clr_reg  <= 1'b1;
		end else begin
			done_reg <= instr_valid_i && (instr_i.op == llij_pkg::OP_END);
			// Only the volatile areas are cleared after power-up.
			clr_reg  <= 1'b0;
		end
	end

	assign fetch_addr_o     = pc_reg;
	assign act_o            = act_reg;
	assign scan_done_o      = done_reg;
	assign il_warn_o        = warn_reg;
	assign clear_volatile_o = clr_reg;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	latch_reset_wins_a: assert property (
		run_now && !il_off_reg && instr_i.op == llij_pkg::OP_LATCH && instr_i.cond_b
		|=> act_o.valid && act_o.mode == llij_pkg::ACT_WRITE && !act_o.value)
		else $error("latch with reset on did not clear bit");
	latch_set_on_a: assert property (
		run_now && !il_off_reg && instr_i.op == llij_pkg::OP_LATCH && instr_i.cond_a && !instr_i.cond_b
		|=> act_o.valid && act_o.value)
		else $error("latch set did not drive bit on");
	latch_il_hold_a: assert property (
		run_now && il_off_reg && instr_i.op == llij_pkg::OP_LATCH |=> !act_o.valid)
		else $error("latch bit touched inside closed interlock");
	out_forced_off_a: assert property (
		run_now && il_off_reg && instr_i.op == llij_pkg::OP_OUT_NOT
		|=> act_o.valid && act_o.mode == llij_pkg::ACT_WRITE && !act_o.value)
		else $error("inverted output not forced off in interlock");
	timer_reset_sv_a: assert property (
		run_now && il_off_reg && instr_i.op == llij_pkg::OP_TIMER_STD
		|=> act_o.mode == llij_pkg::ACT_RESET_SV && act_o.valid)
		else $error("timer not reset in closed interlock");
	jump_direct_a: assert property (
		take_jump && jump_numbered |=> fetch_addr_o == $past(jump_target) && state_reg == ST_RUN)
		else $error("numbered jump missed its jump-end");
	jump_not_taken_a: assert property (
		run_now && !il_off_reg && instr_i.op == llij_pkg::OP_JUMP && instr_i.cond_a
		|=> fetch_addr_o == $past(pc_reg) + llij_pkg::PC_STEP)
		else $error("jump taken with condition on");
	search_skip_a: assert property (
		take_jump && !jump_numbered |=> state_reg == ST_SEARCH ##1 !act_o.valid)
		else $error("jump zero did not enter search");
	search_land_a: assert property (
		instr_valid_i && state_reg == ST_SEARCH && instr_i.op == llij_pkg::OP_JUMP_END
		&& instr_i.jump_num == llij_pkg::JNUM_ANY |=> state_reg == ST_RUN)
		else $error("search passed the next jump-end zero");
	il_clear_all_a: assert property (
		run_now && instr_i.op == llij_pkg::OP_IL_CLEAR |=> !il_off_reg && il_cnt_reg == llij_pkg::IL_CNT_ZERO)
		else $error("interlock clear left an interlock active");
	multi_open_warn_a: assert property (
		run_now && instr_i.op == llij_pkg::OP_IL_CLEAR && il_cnt_reg > llij_pkg::IL_CNT_ONE |=> il_warn_o)
		else $error("no warning for shared interlock clear");
	edge_frozen_a: assert property (
		run_now && il_off_reg && instr_i.op == llij_pkg::OP_RISE
		|=> !act_o.valid && edge_prev_reg[$past(instr_i.edge_idx)] == $past(prev_now))
		else $error("edge memory changed inside closed interlock");

endmodule : llij_scan_engine
